// file: core/ict_cycle_timer.sv
// One bus microcycle: minimum length and wait-state stretching
`timescale 1ns/1ps
`include "ict_defs.svh"

module ict_cycle_timer #(
  parameter int CLK_W = 16
) (
  // Clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 rst_in,
  // Cycle request
  input  wire logic                 start_in,
  input  wire ict_pkg::ict_kind_type kind_in,
  // Memory or DMA ready
  input  wire logic                 ready_in,
  // Cycle status
  output logic                      busy_out,
  output ict_pkg::ict_kind_type     kind_out,
  output logic                      end_out,
  output logic                      stretched_out
);

  logic [CLK_W-1:0] cnt;
  logic [CLK_W-1:0] bound;

  generate
    if (CLK_W < 5) begin : g_chk
      $error("CLK_W too small for a write microcycle");
    end
  endgenerate

  // Ready is only looked at on a stretch boundary
  assign end_out = busy_out && (cnt == bound) && ready_in;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      busy_out      <= 1'b0;
      kind_out      <= ict_pkg::ict_kind_nt;
      cnt           <= '0;
      bound         <= '0;
      stretched_out <= 1'b0;
    end else if (start_in) begin
      busy_out      <= 1'b1;
      kind_out      <= kind_in;
      cnt           <= CLK_W'(1);
      stretched_out <= 1'b0;
      if (kind_in == ict_pkg::ict_kind_write) begin
        bound <= CLK_W'(`ICT_WRITE_MIN_CLK);
      end else if (kind_in == ict_pkg::ict_kind_read) begin
        bound <= CLK_W'(`ICT_READ_MIN_CLK);
      end else begin
        bound <= CLK_W'(`ICT_NT_CLK);
      end
    end else if (busy_out) begin
      if (end_out) begin
        busy_out <= 1'b0;
      end else begin
        cnt <= cnt + CLK_W'(1);
        if (cnt == bound) begin
          stretched_out <= 1'b1;
          // Only an unstretched read or idle cycle gets the long first wait
          if (!stretched_out && kind_out != ict_pkg::ict_kind_write) begin
            bound <= bound + CLK_W'(`ICT_FIRST_WAIT_CLK);
          end else begin
            bound <= bound + CLK_W'(`ICT_WAIT_STEP_CLK);
          end
        end
      end
    end
  end

endmodule

// file: core/ict_defs.svh
// Timing constants and opcode fields for the instruction cycle timing block
`ifndef ICT_DEFS_SVH
`define ICT_DEFS_SVH

// Microcycle lengths in clock periods
`define ICT_READ_MIN_CLK   4
`define ICT_WRITE_MIN_CLK  8
`define ICT_NT_CLK         4
`define ICT_FIRST_WAIT_CLK 4
`define ICT_WAIT_STEP_CLK  2

// Base microcycles, reads, writes per instruction class
`define ICT_SINGLE_MC  1
`define ICT_SINGLE_RD  1
`define ICT_INTERLOCKED_TEST_SET_MC  5
`define ICT_INTERLOCKED_WRITE_MC  4
`define ICT_LOCK_RD    1
`define ICT_LOCK_WR    1
`define ICT_BR_NT_MC   2
`define ICT_BR_TK_MC   4
`define ICT_LOOP_NT_MC 3
`define ICT_LOOP_TK_MC 5
`define ICT_BR_NT_RD   1
`define ICT_BR_TK_RD   2
`define ICT_TRAP_MC    20
`define ICT_TRAP_RD    4
`define ICT_TRAP_WR    2
`define ICT_RTI_MC     9
`define ICT_RTI_RD     4
`define ICT_CC_MC      3
`define ICT_CSM_MC     28
`define ICT_CSM_RD     3
`define ICT_CSM_WR     3
`define ICT_PTYPE_MC   2
`define ICT_SPL_MC     7
`define ICT_STATUS_BYTE_WRITE_MC    8
`define ICT_MARK_MC    10
`define ICT_MARK_RD    3
`define ICT_MFPX_MC    5
`define ICT_MTPX_MC    3
`define ICT_MTPX_RD    2
`define ICT_MUL_MC     22
`define ICT_DIV_MC     34
`define ICT_ASH_MC     4
`define ICT_ASHC_MC    5
`define ICT_FADDD_MIN  41
`define ICT_FADDD_MAX  119
`define ICT_FADDF_MIN  31
`define ICT_FADDF_MAX  102
`define ICT_FABSD_MIN  23
`define ICT_FABSD_MAX  24
`define ICT_FABSF_MIN  19
`define ICT_FABSF_MAX  20

// Opcode fields
`define ICT_OP_RTI     16'h0002
`define ICT_OP_RTT     16'h0006
`define ICT_OP_BPT     16'h0003
`define ICT_OP_IOT     16'h0004
`define ICT_OP_PTYPE   16'h0007
`define ICT_OP_CC_HI   10'h002
`define ICT_OP_SPL_HI  13'h0013
`define ICT_OP_SWAB    10'h003
`define ICT_OP_TRAP_HI 7'h44
`define ICT_OP_SGL_HI  6'h05
`define ICT_OP_SHF_HI  6'h06
`define ICT_OP_MARK    10'h034
`define ICT_OP_MFPI    10'h035
`define ICT_OP_MTPI    10'h036
`define ICT_OP_STATUS_BYTE_WRITE    10'h234
`define ICT_OP_MFPD    10'h235
`define ICT_OP_MTPD    10'h236
`define ICT_OP_CSM     10'h038
`define ICT_OP_INTERLOCKED_TEST_SET  10'h03a
`define ICT_OP_INTERLOCKED_WRITE  10'h03b
`define ICT_OP_REG_HI  4'h7
`define ICT_OP_MUL     7'h38
`define ICT_OP_DIV     7'h39
`define ICT_OP_ASH     7'h3a
`define ICT_OP_ASHC    7'h3b
`define ICT_OP_XOR     7'h3c
`define ICT_OP_LOOP    7'h3f
`define ICT_OP_FADD_HI 7'h7a
`define ICT_OP_FABS_HI 10'h3c6

`endif

// file: core/ict_instr_timing.sv
// Instruction decoder that plays out base and operand microcycles on the bus
`timescale 1ns/1ps
`include "ict_defs.svh"

// Function
// - Read microcycle lasts at least four clocks
// - Write microcycle lasts at least eight clocks
// - Unstretched non-transfer microcycle is four clocks
// - First wait four clocks (two for writes), then two-clock steps
// - Stretched cycle grows two clocks per wait
// - Stretched read: eight clocks, then steps of two
// - Total is base plus operand microcycles
// - Leftover microcycles run as non-transfer cycles
// - Single-operand group: one read microcycle
// - Test-set five, interlocked write four, 1R/1W
// - Double-operand group: one read microcycle
// - Branch: two/one read, taken four/two reads
// - Loop branch: three/one read, taken five/two
// - Traps: twenty microcycles, four reads, two writes
// - Interrupt returns: nine microcycles, four reads
// - Condition code ops: three microcycles, one read
// - Supervisor call: twenty-eight, three reads, three writes
// - Processor type lands in register zero low byte
// - Priority set seven, no-operation three, one read
// - Status byte in eight, out one, one read
// - Floating point length varies between min and max
// - Negative operand count: subtract, add per transfer
module ict_instr_timing #(
  parameter int         MC_W      = 8,
  parameter int         OP_W      = 4,
  parameter int         CLK_W     = 16,
  parameter logic [7:0] PROC_CODE = 8'h05 // Arbitrary value
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // Instruction request
  input  wire logic             start_in,
  input  wire logic [15:0]      instr_in,
  input  wire logic             branch_taken_in,
  input  wire logic             fp_double_in,
  input  wire logic [MC_W-1:0]  fp_extra_in,
  // Operand address calculation
  input  wire logic [OP_W-1:0]  op_mc_in,
  input  wire logic [OP_W-1:0]  op_rd_in,
  input  wire logic [OP_W-1:0]  op_wr_in,
  input  wire logic             op_neg_in,
  // Memory or DMA
  input  wire logic             ready_in,
  // Status
  output logic                  start_ready_out,
  output logic                  busy_out,
  output logic                  done_out,
  output logic                  unknown_out,
  // Bus microcycle
  output logic                  cyc_read_out,
  output logic                  cyc_write_out,
  output logic                  cyc_nt_out,
  output logic                  cyc_end_out,
  output logic                  cyc_stretched_out,
  // General register zero
  output logic                  gpr0_we_out,
  output logic [7:0]            gpr0_data_out,
  // Counters of the last instruction
  output logic [MC_W-1:0]       total_mc_out,
  output logic [MC_W-1:0]       read_mc_out,
  output logic [MC_W-1:0]       write_mc_out,
  output logic [CLK_W-1:0]      clocks_out
);

  localparam int RW_W = 3;
  localparam int SW   = MC_W + 2;

  generate
    if (MC_W < 7 || OP_W < 1 || CLK_W < 5) begin : g_chk
      $error("Counter widths too small for the longest instruction");
    end
  endgenerate

  ict_pkg::ict_state_type state;
  ict_pkg::ict_kind_type  cyc_kind;
  ict_pkg::ict_kind_type  next_kind;

  logic [MC_W-1:0] base_mc;
  logic [RW_W-1:0] base_rd;
  logic [RW_W-1:0] base_wr;
  logic [MC_W-1:0] fp_span;
  logic            dec_unknown;
  logic            dec_ptype;

  logic [SW-1:0]   fp_add;
  logic [SW-1:0]   gross;
  logic [SW-1:0]   debit;
  logic [SW-1:0]   rd_tot;
  logic [SW-1:0]   wr_tot;
  logic [SW-1:0]   xfer;
  logic [SW-1:0]   net;
  logic [SW-1:0]   nt_tot;

  logic [SW-1:0]   rd_left;
  logic [SW-1:0]   wr_left;
  logic [SW-1:0]   nt_left;
  logic [SW-1:0]   rd_after;
  logic [SW-1:0]   wr_after;
  logic [SW-1:0]   nt_after;
  logic            last_cycle;
  logic            timer_start;
  logic            cyc_busy;
  logic            ptype_pending;

  logic [MC_W-1:0]  mc_cnt;
  logic [MC_W-1:0]  rd_cnt;
  logic [MC_W-1:0]  wr_cnt;
  logic [CLK_W-1:0] clk_cnt;

  // Base time per opcode
  always_comb begin
    base_mc     = MC_W'(`ICT_SINGLE_MC);
    base_rd     = RW_W'(`ICT_SINGLE_RD);
    base_wr     = '0;
    fp_span     = '0;
    dec_unknown = 1'b0;
    dec_ptype   = 1'b0;
    if (instr_in == `ICT_OP_RTI || instr_in == `ICT_OP_RTT) begin
      base_mc = MC_W'(`ICT_RTI_MC);
      base_rd = RW_W'(`ICT_RTI_RD);
    end else if (instr_in == `ICT_OP_BPT || instr_in == `ICT_OP_IOT) begin
      base_mc = MC_W'(`ICT_TRAP_MC);
      base_rd = RW_W'(`ICT_TRAP_RD);
      base_wr = RW_W'(`ICT_TRAP_WR);
    end else if (instr_in == `ICT_OP_PTYPE) begin
      base_mc   = MC_W'(`ICT_PTYPE_MC);
      dec_ptype = 1'b1;
    end else if (instr_in[15:6] == `ICT_OP_CC_HI && instr_in[5]) begin
      // Condition code set/clear, no-operation included
      base_mc = MC_W'(`ICT_CC_MC);
    end else if (instr_in[15:3] == `ICT_OP_SPL_HI) begin
      base_mc = MC_W'(`ICT_SPL_MC);
    end else if (instr_in[15:6] == `ICT_OP_SWAB) begin
      base_mc = MC_W'(`ICT_SINGLE_MC);
    end else if (instr_in[14:11] == 4'h0 && (instr_in[15] || instr_in[10:8] != 3'h0)) begin
      if (branch_taken_in) begin
        base_mc = MC_W'(`ICT_BR_TK_MC);
        base_rd = RW_W'(`ICT_BR_TK_RD);
      end else begin
        base_mc = MC_W'(`ICT_BR_NT_MC);
        base_rd = RW_W'(`ICT_BR_NT_RD);
      end
    end else if (instr_in[15:9] == `ICT_OP_TRAP_HI) begin
      base_mc = MC_W'(`ICT_TRAP_MC);
      base_rd = RW_W'(`ICT_TRAP_RD);
      base_wr = RW_W'(`ICT_TRAP_WR);
    end else if (instr_in[14:9] == `ICT_OP_SGL_HI) begin
      base_mc = MC_W'(`ICT_SINGLE_MC);
    end else if (instr_in[14:9] == `ICT_OP_SHF_HI) begin
      case (instr_in[15:6])
        `ICT_OP_MARK: begin
          base_mc = MC_W'(`ICT_MARK_MC);
          base_rd = RW_W'(`ICT_MARK_RD);
        end
        `ICT_OP_MFPI, `ICT_OP_MFPD: begin
          base_mc = MC_W'(`ICT_MFPX_MC);
          base_wr = RW_W'(`ICT_LOCK_WR);
        end
        `ICT_OP_MTPI, `ICT_OP_MTPD: begin
          base_mc = MC_W'(`ICT_MTPX_MC);
          base_rd = RW_W'(`ICT_MTPX_RD);
        end
        `ICT_OP_STATUS_BYTE_WRITE: begin
          base_mc = MC_W'(`ICT_STATUS_BYTE_WRITE_MC);
        end
        default: begin
          // Rotates, shifts, sign extend, status byte read
          base_mc = MC_W'(`ICT_SINGLE_MC);
        end
      endcase
    end else if (instr_in[15:6] == `ICT_OP_CSM) begin
      base_mc = MC_W'(`ICT_CSM_MC);
      base_rd = RW_W'(`ICT_CSM_RD);
      base_wr = RW_W'(`ICT_CSM_WR);
    end else if (instr_in[15:6] == `ICT_OP_INTERLOCKED_TEST_SET) begin
      base_mc = MC_W'(`ICT_INTERLOCKED_TEST_SET_MC);
      base_rd = RW_W'(`ICT_LOCK_RD);
      base_wr = RW_W'(`ICT_LOCK_WR);
    end else if (instr_in[15:6] == `ICT_OP_INTERLOCKED_WRITE) begin
      base_mc = MC_W'(`ICT_INTERLOCKED_WRITE_MC);
      base_rd = RW_W'(`ICT_LOCK_RD);
      base_wr = RW_W'(`ICT_LOCK_WR);
    end else if (instr_in[15:12] == `ICT_OP_REG_HI) begin
      case (instr_in[15:9])
        `ICT_OP_MUL:  base_mc = MC_W'(`ICT_MUL_MC);
        `ICT_OP_DIV:  base_mc = MC_W'(`ICT_DIV_MC);
        `ICT_OP_ASH:  base_mc = MC_W'(`ICT_ASH_MC);
        `ICT_OP_ASHC: base_mc = MC_W'(`ICT_ASHC_MC);
        `ICT_OP_XOR:  base_mc = MC_W'(`ICT_SINGLE_MC);
        `ICT_OP_LOOP: begin
          if (branch_taken_in) begin
            base_mc = MC_W'(`ICT_LOOP_TK_MC);
            base_rd = RW_W'(`ICT_BR_TK_RD);
          end else begin
            base_mc = MC_W'(`ICT_LOOP_NT_MC);
            base_rd = RW_W'(`ICT_BR_NT_RD);
          end
        end
        default: dec_unknown = 1'b1;
      endcase
    end else if (instr_in[14:12] != 3'h0 && instr_in[14:12] != 3'h7) begin
      base_mc = MC_W'(`ICT_SINGLE_MC);
    end else if (instr_in[15:9] == `ICT_OP_FADD_HI) begin
      // Data-dependent length between the two figures
      base_mc = fp_double_in ? MC_W'(`ICT_FADDD_MIN) : MC_W'(`ICT_FADDF_MIN);
      fp_span = fp_double_in ? MC_W'(`ICT_FADDD_MAX - `ICT_FADDD_MIN)
                             : MC_W'(`ICT_FADDF_MAX - `ICT_FADDF_MIN);
    end else if (instr_in[15:6] == `ICT_OP_FABS_HI) begin
      base_mc = fp_double_in ? MC_W'(`ICT_FABSD_MIN) : MC_W'(`ICT_FABSF_MIN);
      fp_span = fp_double_in ? MC_W'(`ICT_FABSD_MAX - `ICT_FABSD_MIN)
                             : MC_W'(`ICT_FABSF_MAX - `ICT_FABSF_MIN);
    end else begin
      // Unlisted opcodes still cost their fetch read
      dec_unknown = 1'b1;
    end
  end

  // Instruction totals from base and operand figures
  always_comb begin
    fp_add = (fp_extra_in > fp_span) ? SW'(fp_span) : SW'(fp_extra_in);
    rd_tot = SW'(base_rd) + SW'(op_rd_in);
    wr_tot = SW'(base_wr) + SW'(op_wr_in);
    xfer   = rd_tot + wr_tot;
    if (op_neg_in) begin
      gross = SW'(base_mc) + fp_add + SW'(op_rd_in) + SW'(op_wr_in);
      debit = SW'(op_mc_in);
    end else begin
      gross = SW'(base_mc) + fp_add + SW'(op_mc_in);
      debit = '0;
    end
    net = (gross > debit) ? gross - debit : '0;
    // Every transfer needs a microcycle of its own
    if (net < xfer) begin
      net = xfer;
    end
    nt_tot = net - xfer;
  end

  // Remaining cycles and the kind of the next one
  always_comb begin
    if (state == ict_pkg::ict_st_idle) begin
      rd_after = rd_tot;
      wr_after = wr_tot;
      nt_after = nt_tot;
    end else begin
      rd_after = rd_left;
      wr_after = wr_left;
      nt_after = nt_left;
      if (cyc_end_out) begin
        unique case (cyc_kind)
          ict_pkg::ict_kind_read:  rd_after = rd_left - SW'(1);
          ict_pkg::ict_kind_write: wr_after = wr_left - SW'(1);
          ict_pkg::ict_kind_nt:    nt_after = nt_left - SW'(1);
        endcase
      end
    end
    // Reads first, idle cycles, then writes
    if (rd_after != '0) begin
      next_kind = ict_pkg::ict_kind_read;
    end else if (nt_after != '0) begin
      next_kind = ict_pkg::ict_kind_nt;
    end else begin
      next_kind = ict_pkg::ict_kind_write;
    end
    last_cycle = (rd_after == '0) && (wr_after == '0) && (nt_after == '0);
  end

  assign start_ready_out = (state == ict_pkg::ict_st_idle);
  assign busy_out        = (state == ict_pkg::ict_st_run);
  assign timer_start     = (start_ready_out && start_in) ||
                           (busy_out && cyc_end_out && !last_cycle);

  ict_cycle_timer #(
    .CLK_W(CLK_W)
  ) u_timer (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .start_in      (timer_start),
    .kind_in       (next_kind),
    .ready_in      (ready_in),
    .busy_out      (cyc_busy),
    .kind_out      (cyc_kind),
    .end_out       (cyc_end_out),
    .stretched_out (cyc_stretched_out)
  );

  assign cyc_read_out  = cyc_busy && (cyc_kind == ict_pkg::ict_kind_read);
  assign cyc_write_out = cyc_busy && (cyc_kind == ict_pkg::ict_kind_write);
  assign cyc_nt_out    = cyc_busy && (cyc_kind == ict_pkg::ict_kind_nt);

  // Sequencer
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= ict_pkg::ict_st_idle;
    end else begin
      unique case (state)
        ict_pkg::ict_st_idle: begin
          if (start_in) begin
            state <= ict_pkg::ict_st_run;
          end
        end
        ict_pkg::ict_st_run: begin
          if (cyc_end_out && last_cycle) begin
            state <= ict_pkg::ict_st_idle;
          end
        end
        default: state <= ict_pkg::ict_st_idle;
      endcase
    end
  end

  // Cycles still owed by the current instruction
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_left <= '0;
      wr_left <= '0;
      nt_left <= '0;
    end else if ((start_ready_out && start_in) || cyc_end_out) begin
      rd_left <= rd_after;
      wr_left <= wr_after;
      nt_left <= nt_after;
    end
  end

  // Live counters, restarted with each instruction
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mc_cnt  <= '0;
      rd_cnt  <= '0;
      wr_cnt  <= '0;
      clk_cnt <= '0;
    end else if (start_ready_out && start_in) begin
      mc_cnt  <= '0;
      rd_cnt  <= '0;
      wr_cnt  <= '0;
      clk_cnt <= '0;
    end else if (busy_out) begin
      // Wraps if memory stalls past the counter range
      clk_cnt <= clk_cnt + CLK_W'(1);
      if (cyc_end_out) begin
        mc_cnt <= mc_cnt + MC_W'(1);
        if (cyc_read_out) begin
          rd_cnt <= rd_cnt + MC_W'(1);
        end
        if (cyc_write_out) begin
          wr_cnt <= wr_cnt + MC_W'(1);
        end
      end
    end
  end

  // Results latched when the last microcycle ends
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      done_out     <= 1'b0;
      total_mc_out <= '0;
      read_mc_out  <= '0;
      write_mc_out <= '0;
      clocks_out   <= '0;
    end else begin
      done_out <= busy_out && cyc_end_out && last_cycle;
      if (busy_out && cyc_end_out && last_cycle) begin
        total_mc_out <= mc_cnt + MC_W'(1);
        read_mc_out  <= rd_cnt + MC_W'(cyc_read_out);
        write_mc_out <= wr_cnt + MC_W'(cyc_write_out);
        clocks_out   <= clk_cnt + CLK_W'(1);
      end
    end
  end

  // Decode flags and the register zero write
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      unknown_out   <= 1'b0;
      ptype_pending <= 1'b0;
      gpr0_we_out   <= 1'b0;
      gpr0_data_out <= '0;
    end else begin
      gpr0_we_out <= ptype_pending && busy_out && cyc_end_out && last_cycle;
      if (start_ready_out && start_in) begin
        unknown_out   <= dec_unknown;
        ptype_pending <= dec_ptype;
        if (dec_ptype) begin
          gpr0_data_out <= PROC_CODE;
        end
      end
    end
  end

endmodule

// file: core/ict_pkg.sv
// Types shared by the instruction cycle timing block
package ict_pkg;
  typedef enum logic [1:0] {
    ict_st_idle = 2'b01,
    ict_st_run  = 2'b10
  } ict_state_type;

  typedef enum logic [2:0] {
    ict_kind_read  = 3'b001,
    ict_kind_write = 3'b010,
    ict_kind_nt    = 3'b100
  } ict_kind_type;
endpackage

// file: testbench/ict_mem_model.sv
// Memory or DMA master that holds ready low for part of each microcycle
`timescale 1ns/1ps

module ict_mem_model (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Microcycle from the processor
  input  wire logic       cyc_read_in,
  input  wire logic       cyc_write_in,
  input  wire logic       cyc_nt_in,
  input  wire logic       cyc_end_in,
  // Clocks of each microcycle during which waits are demanded
  input  wire logic [7:0] hold_in,
  // Ready to the processor
  output logic            ready_out
);
  logic [7:0] clk_cnt;

  // First clock of a microcycle counts as one
  always_ff @(posedge clk_in) begin
    if (rst_in || cyc_end_in || !(cyc_read_in || cyc_write_in || cyc_nt_in)) begin
      clk_cnt <= 8'h01;
    end else begin
      clk_cnt <= clk_cnt + 8'h01;
    end
  end

  // Slow memory and DMA both stretch by holding ready low
  assign ready_out = (clk_cnt > hold_in);
endmodule

// file: testbench/ict_timing_props.sv
// Assertions on the ports of the instruction cycle timing block
`timescale 1ns/1ps

module ict_timing_props #(
  parameter logic [7:0] PROC_CODE = 8'h05
) (
  // Clock and reset
  input wire logic       clk_in,
  input wire logic       rst_in,
  // Bus side
  input wire logic       ready_in,
  input wire logic       cyc_read_out,
  input wire logic       cyc_write_out,
  input wire logic       cyc_nt_out,
  input wire logic       cyc_end_out,
  input wire logic       cyc_stretched_out,
  // Status and register zero
  input wire logic       busy_out,
  input wire logic       done_out,
  input wire logic       gpr0_we_out,
  input wire logic [7:0] gpr0_data_out
);
  logic [7:0] len;
  logic       any_cyc;

  assign any_cyc = cyc_read_out || cyc_write_out || cyc_nt_out;

  // Clocks already spent in the current microcycle, zero on its first clock
  always_ff @(posedge clk_in) begin
    if (rst_in || cyc_end_out || !any_cyc) begin
      len <= 8'h00;
    end else begin
      len <= len + 8'h01;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  chk_read_min: assert property (cyc_read_out && cyc_end_out |-> len >= 8'h03)
    else $error("read microcycle too short");
  chk_write_min: assert property (cyc_write_out && cyc_end_out |-> len >= 8'h07 && len[0])
    else $error("write microcycle too short or odd");
  chk_nt_plain: assert property (cyc_nt_out && cyc_end_out && !cyc_stretched_out |-> len == 8'h03)
    else $error("plain non-transfer cycle not four clocks");
  chk_plain_end: assert property ((cyc_read_out || cyc_nt_out) && !cyc_stretched_out
      && len == 8'h03 && ready_in |-> cyc_end_out)
    else $error("ready cycle did not end at four clocks");
  chk_first_wait: assert property ((cyc_read_out || cyc_nt_out) && !cyc_stretched_out
      && len == 8'h03 && !ready_in |=> cyc_stretched_out && !cyc_end_out
      && $stable(cyc_read_out))
    else $error("wait at first boundary not taken");
  chk_stretch_len: assert property (cyc_end_out && cyc_stretched_out && !cyc_write_out
      |-> len >= 8'h07 && len[0])
    else $error("stretched cycle length wrong");
  chk_step_end: assert property ((cyc_stretched_out || cyc_write_out) && len >= 8'h07
      && len[0] && ready_in |-> cyc_end_out)
    else $error("stretched cycle missed its two-clock boundary");
  chk_end_ready: assert property (cyc_end_out |-> ready_in && any_cyc)
    else $error("cycle ended without ready");
  chk_one_kind: assert property ($onehot0({cyc_read_out, cyc_write_out, cyc_nt_out}))
    else $error("more than one microcycle kind");
  chk_done_after: assert property (done_out |-> $past(cyc_end_out) && !busy_out && !any_cyc)
    else $error("done not right after last cycle end");
  chk_proc_code: assert property (gpr0_we_out |-> done_out && gpr0_data_out == PROC_CODE)
    else $error("register zero write wrong");

  cov_stretch: cover property (cyc_end_out && cyc_stretched_out);
endmodule

// file: testbench/instruction_cycle_timing_tb.sv
// Self-checking bench of the instruction cycle timing block
`timescale 1ns/1ps

module instruction_cycle_timing_tb;
  typedef struct packed {
    logic [15:0] op;
    logic        tk, fd, ng, pad;
    logic [7:0]  fx;
    logic [3:0]  mc, rd, wr;
    logic [7:0]  et;
    logic [3:0]  er, ew;
  } ict_row_type;

  logic        clk_in, rst_in, start_in, branch_taken_in, fp_double_in, op_neg_in, ready_in;
  logic [15:0] instr_in, clocks_out;
  logic [7:0]  fp_extra_in, hold, gpr0_data_out, total_mc_out, read_mc_out, write_mc_out;
  logic [3:0]  op_mc_in, op_rd_in, op_wr_in;
  logic        start_ready_out, busy_out, done_out, unknown_out, gpr0_we_out;
  logic        cyc_read_out, cyc_write_out, cyc_nt_out, cyc_end_out, cyc_stretched_out;
  int          err_total, checks_done;

  // Op, flags (taken 8, double 4, negative 2), extra, mc rd wr, total, reads writes
  ict_row_type rows [25] = '{
    56'h0a00_0_00_000_01_10, 56'h0e80_0_00_000_05_11, 56'h0ec0_0_00_000_04_11,
    56'h1000_0_00_311_04_21, 56'h0100_0_00_000_02_10, 56'h0100_8_00_000_04_20,
    56'h7e00_0_00_000_03_10, 56'h7e00_8_00_000_05_20, 56'h8800_0_00_000_14_42,
    56'h0003_0_00_000_14_42, 56'h0004_0_00_000_14_42, 56'h0002_0_00_000_09_40,
    56'h0006_0_00_000_09_40, 56'h00a1_0_00_000_03_10, 56'h00bf_0_00_000_03_10,
    56'h0007_0_00_000_02_10, 56'h0098_0_00_000_07_10, 56'h00a0_0_00_000_03_10,
    56'h8d00_0_00_000_08_10, 56'h8dc0_0_00_000_01_10, 56'hf400_4_00_000_29_10,
    56'hf400_4_64_000_77_10, 56'hf400_2_00_110_1f_20, 56'h0e00_0_00_000_1c_33,
    56'h0000_0_00_000_01_10};

  ict_instr_timing ict_instr_timing_i (.clk_in(clk_in), .rst_in(rst_in), .start_in(start_in),
    .instr_in(instr_in), .branch_taken_in(branch_taken_in), .fp_double_in(fp_double_in),
    .fp_extra_in(fp_extra_in), .op_mc_in(op_mc_in), .op_rd_in(op_rd_in), .op_wr_in(op_wr_in),
    .op_neg_in(op_neg_in), .ready_in(ready_in), .start_ready_out(start_ready_out),
    .busy_out(busy_out), .done_out(done_out), .unknown_out(unknown_out),
    .cyc_read_out(cyc_read_out), .cyc_write_out(cyc_write_out), .cyc_nt_out(cyc_nt_out),
    .cyc_end_out(cyc_end_out), .cyc_stretched_out(cyc_stretched_out),
    .gpr0_we_out(gpr0_we_out), .gpr0_data_out(gpr0_data_out), .total_mc_out(total_mc_out),
    .read_mc_out(read_mc_out), .write_mc_out(write_mc_out), .clocks_out(clocks_out));

  ict_mem_model ict_mem_model_i (.clk_in(clk_in), .rst_in(rst_in), .cyc_read_in(cyc_read_out),
    .cyc_write_in(cyc_write_out), .cyc_nt_in(cyc_nt_out), .cyc_end_in(cyc_end_out),
    .hold_in(hold), .ready_out(ready_in));

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  task automatic summarize();
    if (err_total == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Clocks of one microcycle of base length b while ready is low for h clocks
  function automatic int plen(input int b, input int h);
    int n;
    n = b;
    if (h >= n) n = (n == 4) ? 8 : n + 2;
    while (h >= n) n += 2;
    return n;
  endfunction

  task automatic run(input ict_row_type r, input logic [7:0] h, input int extra);
    int n;
    int exp_clk;
    exp_clk = (r.et - r.ew) * plen(4, h) + r.ew * plen(8, h);
    hold <= h;
    instr_in <= r.op;
    branch_taken_in <= r.tk;
    fp_double_in <= r.fd;
    fp_extra_in <= r.fx;
    op_mc_in <= r.mc;
    op_rd_in <= r.rd;
    op_wr_in <= r.wr;
    op_neg_in <= r.ng;
    start_in <= 1'b1;
    @(posedge clk_in);
    // Starts while busy must be ignored
    repeat (extra) begin
      instr_in <= 16'h8800;
      @(posedge clk_in);
    end
    start_in <= 1'b0;
    // Registered results are looked at mid-cycle, clear of the launching edge
    for (n = 0; n < 800 && done_out !== 1'b1; n++) @(negedge clk_in);
    check(done_out, 1'b1);
    check(unknown_out, r.op == 16'h0000);
    check(total_mc_out, r.et);
    check(read_mc_out, r.er);
    check(write_mc_out, r.ew);
    check(clocks_out, exp_clk);
    check(gpr0_we_out, r.op == 16'h0007);
    @(posedge clk_in);
  endtask

  initial begin
    repeat (20000) @(posedge clk_in);
    err_total++;
    summarize();
  end

  initial begin
    {rst_in, start_in, branch_taken_in, fp_double_in, op_neg_in} = 5'h10;
    {instr_in, fp_extra_in, hold, op_mc_in, op_rd_in, op_wr_in} = 44'h0;
    err_total = 0;
    checks_done = 0;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    check({start_ready_out, busy_out, done_out, total_mc_out, clocks_out}, 32'h4000000);
    foreach (rows[i]) run(rows[i], 8'h00, 0);
    run(rows[17], 8'h04, 0);
    run(rows[23], 8'h08, 0);
    run(rows[3], 8'h09, 3);
    run(rows[8], 8'h0c, 0);
    // Reset in mid-run must clear counters and end the instruction
    instr_in <= 16'h0e00;
    start_in <= 1'b1;
    @(posedge clk_in);
    start_in <= 1'b0;
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    check({start_ready_out, busy_out, cyc_read_out, total_mc_out, clocks_out}, 32'h4000000);
    run(rows[17], 8'h00, 0);
    summarize();
  end
endmodule

bind ict_instr_timing ict_timing_props #(.PROC_CODE(PROC_CODE)) ict_timing_props_i (
  .clk_in(clk_in), .rst_in(rst_in), .ready_in(ready_in), .cyc_read_out(cyc_read_out),
  .cyc_write_out(cyc_write_out), .cyc_nt_out(cyc_nt_out), .cyc_end_out(cyc_end_out),
  .cyc_stretched_out(cyc_stretched_out), .busy_out(busy_out), .done_out(done_out),
  .gpr0_we_out(gpr0_we_out), .gpr0_data_out(gpr0_data_out));
